/* File: rtl/dsr_pkg.sv */
// Package for the self refresh handover controller
package dsr_pkg;
  localparam int CLK_MHZ = 250;
  localparam int ROW_BITS = 10;
  localparam int REFRESH_ROWS = 1024;
  localparam int PERIOD_US = 16400;
  localparam int LONG_SR_MS = 300;
  localparam int ROW_ONLY_GAP_US = 16;
  localparam int GAP_MARGIN_US = 2;
  localparam int DIST_GAP_US = ROW_ONLY_GAP_US - GAP_MARGIN_US;
  localparam int DIST_GAP_CYC = DIST_GAP_US * CLK_MHZ;
  localparam int BURST_WINDOW_US = PERIOD_US / 2;
  localparam longint BURST_WINDOW_CYC = longint'(BURST_WINDOW_US) * CLK_MHZ;
  localparam longint LONG_SR_CYC = longint'(LONG_SR_MS) * 1000 * CLK_MHZ;
  localparam int RAS_LOW_CYC = 20;
  localparam int RAS_HIGH_CYC = 20;
  localparam int CAS_LEAD_CYC = 3;
  localparam int TIMER_W = 40;
  localparam int PH_W = 6;
  typedef enum logic [1:0] {
    DSR_CBR_DIST, DSR_ROW_DIST, DSR_CBR_BURST, DSR_ROW_BURST
  } dsr_scheme_t;
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic [ROW_BITS-1:0] addr;
  } dsr_pins_t;
endpackage

/* File: rtl/dsr_timer.sv */
// Elapsed cycle counter with restart and saturation
`timescale 1ns/1ps
module dsr_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic restart,
  // Count
  output logic [dsr_pkg::TIMER_W-1:0] count
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (ce) begin
      if (restart) begin
        count <= '0;
      end else if (count != '1) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule

/* File: rtl/dsr_cycle_gen.sv */
// One refresh cycle waveform generator, cas-first or row-only
`timescale 1ns/1ps
module dsr_cycle_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Request
  input wire logic start,
  input wire logic cas_first,
  input wire logic [dsr_pkg::ROW_BITS-1:0] row,
  // Status and pins
  output logic busy,
  output logic ras_fall,
  output dsr_pkg::dsr_pins_t pins
);
  logic [dsr_pkg::PH_W-1:0] ph_reg;
  logic cbr_reg;
  localparam logic [dsr_pkg::PH_W-1:0] LOW_END =
    dsr_pkg::PH_W'(dsr_pkg::CAS_LEAD_CYC + dsr_pkg::RAS_LOW_CYC);
  localparam logic [dsr_pkg::PH_W-1:0] CYC_END =
    dsr_pkg::PH_W'(dsr_pkg::CAS_LEAD_CYC + dsr_pkg::RAS_LOW_CYC + dsr_pkg::RAS_HIGH_CYC);
  localparam logic [dsr_pkg::PH_W-1:0] LEAD =
    dsr_pkg::PH_W'(dsr_pkg::CAS_LEAD_CYC);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ph_reg <= '0;
      busy <= 1'b0;
      cbr_reg <= 1'b0;
    end else if (ce) begin
      if (!busy && start) begin
        busy <= 1'b1;
        ph_reg <= '0;
        cbr_reg <= cas_first;
      end else if (busy) begin
        if (ph_reg == CYC_END) begin
          busy <= 1'b0;
        end
        ph_reg <= ph_reg + 1'b1;
      end
    end
  end
  // Cas leads ras for cas-first; row-only holds cas high and drives the row
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins <= '{ras_n: 1'b1, cas_n: 1'b1, addr: '0};
      ras_fall <= 1'b0;
    end else if (ce) begin
      ras_fall <= busy && ph_reg == LEAD;
      pins.ras_n <= !(busy && ph_reg >= LEAD && ph_reg < LOW_END);
      pins.cas_n <= !(busy && cbr_reg && ph_reg < LOW_END);
      if (!busy && start) begin
        pins.addr <= row;
      end
    end
  end
endmodule

/* File: rtl/dsr_ctrl.sv */
// Refresh scheduler that hands a dram into and out of self refresh
// Behaviour
// R1 - Long self refresh of 300 ms or more forces the long-case catch-up limits.
// R2 - Cas-first distributed: over 1024 spaced cycles every 16.4 ms.
// R3 - Row-only distributed: all 1024 row addresses, spaced, within 16.4 ms.
// R4 - Cas-first distributed entry gap: last refresh fall to self refresh fall.
// R5 - Cas-first distributed exit gap; entry plus exit gap within 16.4 ms.
// R6 - Row-only distributed: enter self refresh within 16 us of last fall.
// R7 - Row-only distributed: first refresh within 16 us of self refresh exit.
// R8 - Cas-first burst: over 1024 back-to-back cycles within 16.4 ms.
// R9 - Row-only burst: 1024 back-to-back cycles stepping all rows in 16.4 ms.
// R10 - Cas-first burst: burst-to-entry and exit-to-burst gaps each within 16.4 ms.
// R11 - Row-only burst: both burst gaps together within 16.4 ms.
// R12 - After 300 ms or longer self refresh, full refresh within 16.4 ms of exit.
// R13 - After every exit, 1024 refresh cycles within 16.4 ms of ras rising.
// R14 - Own-clock counters track time since last refresh and since exit.
`timescale 1ns/1ps
module dsr_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // User control
  input wire logic [1:0] scheme,
  input wire logic sr_req,
  // Status
  output logic in_self_refresh,
  output logic catchup_busy,
  output logic long_sr_seen,
  // Dram pins
  output logic ras_n,
  output logic cas_n,
  output logic [dsr_pkg::ROW_BITS-1:0] addr
);
  typedef enum logic [2:0] {
    ST_RUN, ST_PRE_BURST, ST_ENTER, ST_SELF, ST_EXIT, ST_CATCHUP
  } dsr_state_t;
  dsr_state_t state_reg;
  dsr_pkg::dsr_scheme_t mode_reg;
  logic [dsr_pkg::ROW_BITS:0] cnt_reg;
  logic [dsr_pkg::ROW_BITS-1:0] row_reg;
  logic gen_start;
  logic gen_cas_first;
  logic gen_busy;
  logic gen_fall;
  dsr_pkg::dsr_pins_t gen_pins;
  logic [dsr_pkg::TIMER_W-1:0] since_ref;
  logic [dsr_pkg::TIMER_W-1:0] since_exit;
  logic exit_restart;
  logic sr_fall_reg;
  logic sr_ras_n_reg;
  logic sr_cas_n_reg;
  localparam logic [dsr_pkg::TIMER_W-1:0] DIST_GAP =
    dsr_pkg::TIMER_W'(dsr_pkg::DIST_GAP_CYC);
  localparam logic [dsr_pkg::TIMER_W-1:0] LONG_SR =
    dsr_pkg::TIMER_W'(dsr_pkg::LONG_SR_CYC);
  localparam logic [dsr_pkg::ROW_BITS:0] ALL_ROWS =
    (dsr_pkg::ROW_BITS+1)'(dsr_pkg::REFRESH_ROWS);

  function automatic logic is_burst(input dsr_pkg::dsr_scheme_t m);
    return m == dsr_pkg::DSR_CBR_BURST || m == dsr_pkg::DSR_ROW_BURST;
  endfunction
  function automatic logic is_cbr(input dsr_pkg::dsr_scheme_t m);
    return m == dsr_pkg::DSR_CBR_DIST || m == dsr_pkg::DSR_CBR_BURST;
  endfunction

  dsr_timer u_since_ref (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .restart(gen_fall),
    .count(since_ref)
  );
  dsr_timer u_since_exit (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .restart(exit_restart),
    .count(since_exit)
  );
  dsr_cycle_gen u_gen (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .start(gen_start),
    .cas_first(gen_cas_first),
    .row(row_reg),
    .busy(gen_busy),
    .ras_fall(gen_fall),
    .pins(gen_pins)
  );

  assign gen_cas_first = is_cbr(mode_reg);
  assign exit_restart = state_reg == ST_SELF && !sr_req;

  // Distributed refresh every DIST_GAP keeps 1024 rows well inside 16.4 ms
  always_comb begin
    gen_start = 1'b0;
    unique case (state_reg)
      // No new cycle once entry is asked for, so entry never overlaps a refresh
      ST_RUN: gen_start = !gen_busy && !sr_req && since_ref >= DIST_GAP; // see R2 see R3 see R14
      ST_PRE_BURST: gen_start = !gen_busy && cnt_reg != ALL_ROWS; // see R8 see R9
      ST_ENTER: gen_start = 1'b0;
      ST_SELF: gen_start = 1'b0;
      ST_EXIT: gen_start = 1'b0;
      ST_CATCHUP: gen_start = !gen_busy && cnt_reg != ALL_ROWS; // see R13
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RUN;
      mode_reg <= dsr_pkg::DSR_CBR_DIST;
      cnt_reg <= '0;
    end else if (ce) begin
      unique case (state_reg)
        ST_RUN: begin
          if (!gen_busy) begin
            mode_reg <= dsr_pkg::dsr_scheme_t'(scheme);
          end
          if (sr_req && !gen_busy) begin
            cnt_reg <= '0;
            // Burst schemes refresh everything right before entry
            state_reg <= is_burst(dsr_pkg::dsr_scheme_t'(scheme)) ? ST_PRE_BURST : ST_ENTER;
          end
        end
        ST_PRE_BURST: begin
          if (gen_start) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
          if (cnt_reg == ALL_ROWS && !gen_busy) begin
            state_reg <= ST_ENTER; // see R10 see R11
          end
        end
        ST_ENTER: begin
          state_reg <= ST_SELF; // see R4 see R6
        end
        ST_SELF: begin
          if (!sr_req) begin
            state_reg <= ST_EXIT;
          end
        end
        ST_EXIT: begin
          // Ras high for one precharge before the catch-up starts
          if (since_exit >= dsr_pkg::TIMER_W'(dsr_pkg::RAS_HIGH_CYC)) begin
            cnt_reg <= '0;
            state_reg <= ST_CATCHUP; // see R5 see R7
          end
        end
        ST_CATCHUP: begin
          if (gen_start) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
          if (cnt_reg == ALL_ROWS && !gen_busy) begin
            state_reg <= ST_RUN; // see R12 see R13
          end
        end
      endcase
    end
  end

  // Row counter wraps over all ten-bit rows
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      row_reg <= '0;
    end else if (ce && gen_start) begin
      row_reg <= row_reg + 1'b1; // see R3 see R9
    end
  end

  // Self refresh strobe: cas low first, then ras held low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sr_ras_n_reg <= 1'b1;
      sr_cas_n_reg <= 1'b1;
      sr_fall_reg <= 1'b0;
    end else if (ce) begin
      sr_fall_reg <= state_reg == ST_ENTER;
      sr_cas_n_reg <= !(state_reg == ST_ENTER || state_reg == ST_SELF);
      sr_ras_n_reg <= !(sr_fall_reg || (state_reg == ST_SELF && !sr_cas_n_reg));
    end
  end

  // Long self refresh flag; catch-up is always a full refresh anyway
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      long_sr_seen <= 1'b0;
    end else if (ce) begin
      if (state_reg == ST_ENTER) begin
        long_sr_seen <= 1'b0;
      end else if (state_reg == ST_SELF && since_ref >= LONG_SR) begin
        long_sr_seen <= 1'b1; // see R1 see R12
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ras_n <= 1'b1;
      cas_n <= 1'b1;
      addr <= '0;
      in_self_refresh <= 1'b0;
      catchup_busy <= 1'b0;
    end else if (ce) begin
      ras_n <= gen_pins.ras_n && sr_ras_n_reg;
      cas_n <= gen_pins.cas_n && sr_cas_n_reg;
      addr <= gen_pins.addr;
      // Reported only once ras is really held low
      in_self_refresh <= state_reg == ST_SELF && !sr_ras_n_reg;
      catchup_busy <= state_reg == ST_EXIT || state_reg == ST_CATCHUP;
    end
  end

endmodule

/* File: verification/dsr_ctrl_monitor.sv */
// Checker for the self refresh handover controller
`timescale 1ns/1ps
module dsr_ctrl_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // User side
  input wire logic [1:0] scheme,
  input wire logic sr_req,
  input wire logic in_self_refresh,
  input wire logic catchup_busy,
  input wire logic long_sr_seen,
  // Dram pins
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic [dsr_pkg::ROW_BITS-1:0] addr
);
  localparam int GAP_LIM = dsr_pkg::ROW_ONLY_GAP_US * dsr_pkg::CLK_MHZ;
  localparam int REF_LIM = dsr_pkg::PERIOD_US * dsr_pkg::CLK_MHZ;
  logic ras_d_reg;
  logic fall;
  int gap_reg;
  int fall_reg;
  int cu_reg;
  logic [dsr_pkg::ROW_BITS-1:0] row_reg;
  logic row_ok_reg;
  int ex_reg;
  logic ex_wait_reg;
  assign fall = ras_d_reg & ~ras_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ras_d_reg <= 1'b1;
      gap_reg <= 0;
    end else begin
      ras_d_reg <= ras_n;
      gap_reg <= fall ? 1 : gap_reg + 1;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fall_reg <= 0;
      cu_reg <= 0;
    end else if (!catchup_busy) begin
      fall_reg <= 0;
      cu_reg <= 0;
    end else begin
      fall_reg <= fall_reg + int'(fall);
      cu_reg <= cu_reg + 1;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      row_ok_reg <= 1'b0;
      row_reg <= '0;
    end else if (fall) begin
      row_ok_reg <= cas_n;
      row_reg <= addr;
    end
  end
  // Cycles from leaving self refresh to the first refresh fall
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ex_wait_reg <= 1'b0;
      ex_reg <= 0;
    end else if (in_self_refresh) begin
      ex_wait_reg <= 1'b1;
      ex_reg <= 0;
    end else if (ex_wait_reg) begin
      ex_wait_reg <= !fall;
      ex_reg <= ex_reg + 1;
    end
  end
  property p_cas_lead; fall && !cas_n && !in_self_refresh |-> !$past(cas_n, 3); endproperty
  a_cas_lead: assert property (p_cas_lead) else $error("cas lead short");
  // Entry strobe leads by one cycle only
  property p_entry_lead; fall && in_self_refresh |-> !$past(cas_n); endproperty
  a_entry_lead: assert property (p_entry_lead) else $error("entry cas lead short");
  property p_self_low; in_self_refresh && sr_req |-> !ras_n && !cas_n; endproperty
  a_self_low: assert property (p_self_low) else $error("strobes up in self refresh");
  property p_entry_req; $rose(in_self_refresh) |-> $past(sr_req); endproperty
  a_entry_req: assert property (p_entry_req) else $error("entry without request");
  property p_gap; fall && !catchup_busy && !scheme[1] |-> gap_reg <= GAP_LIM; endproperty
  a_gap: assert property (p_gap) else $error("refresh gap too long");
  property p_exit_first; ex_wait_reg |-> ex_reg <= GAP_LIM; endproperty
  a_exit_first: assert property (p_exit_first) else $error("late first refresh");
  property p_catchup; $fell(catchup_busy) |-> fall_reg >= dsr_pkg::REFRESH_ROWS; endproperty
  a_catchup: assert property (p_catchup) else $error("catch-up too short");
  property p_cu_time; catchup_busy |-> cu_reg < REF_LIM; endproperty
  a_cu_time: assert property (p_cu_time) else $error("catch-up too slow");
  property p_row_step; fall && cas_n && row_ok_reg |-> addr == row_reg + 1'b1; endproperty
  a_row_step: assert property (p_row_step) else $error("row not stepped");
  property p_freeze; !ce |=> $stable(ras_n) && $stable(cas_n) && $stable(addr); endproperty
  a_freeze: assert property (p_freeze) else $error("pins moved while frozen");
  c_self: cover property ($rose(in_self_refresh));
  c_catchup: cover property ($fell(catchup_busy));
  c_row: cover property (fall && cas_n && row_ok_reg);
endmodule
bind dsr_ctrl dsr_ctrl_monitor u_mon (.core_clk, .rst, .ce, .scheme, .sr_req,
  .in_self_refresh, .catchup_busy, .long_sr_seen, .ras_n, .cas_n, .addr);

/* File: verification/dsr_dram_model.sv */
// Behavioural dram that counts the refresh cycles seen at its pins
`timescale 1ns/1ps
module dsr_dram_model (
  // Sampling clock
  input wire logic core_clk,
  // Dram pins
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic [dsr_pkg::ROW_BITS-1:0] addr,
  // Observed counts
  output int cbr_cnt,
  output int row_cnt,
  output int gap_cyc,
  output logic [dsr_pkg::ROW_BITS-1:0] last_row
);
  logic ras_d;
  int since;
  initial begin
    ras_d = 1'b1;
    since = 0;
    cbr_cnt = 0;
    row_cnt = 0;
    gap_cyc = 0;
    last_row = '0;
  end
  // Real part has no clock; core_clk only samples the strobes
  always @(posedge core_clk) begin
    ras_d <= ras_n;
    since <= since + 1;
    if (ras_d && !ras_n) begin
      gap_cyc <= since;
      since <= 1;
      if (!cas_n) begin
        cbr_cnt <= cbr_cnt + 1;
      end else begin
        row_cnt <= row_cnt + 1;
        last_row <= addr;
      end
    end
  end
endmodule

/* File: verification/tb.sv */
// Testbench for the self refresh handover controller
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] scheme = 2'h0;
  logic sr_req = 1'b0;
  logic in_self_refresh, catchup_busy, long_sr_seen, ras_n, cas_n;
  logic [dsr_pkg::ROW_BITS-1:0] addr, last_row, prev;
  int cbr_cnt, row_cnt, gap_cyc, base;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  localparam int GAP_CYC = dsr_pkg::ROW_ONLY_GAP_US * dsr_pkg::CLK_MHZ;
  dsr_ctrl dut (.core_clk, .rst, .ce, .scheme, .sr_req, .in_self_refresh, .catchup_busy,
    .long_sr_seen, .ras_n, .cas_n, .addr);
  dsr_dram_model mem (.core_clk, .ras_n, .cas_n, .addr, .cbr_cnt, .row_cnt, .gap_cyc,
    .last_row);
  initial forever #2 core_clk = ~core_clk;
  task automatic stop_test();
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_v(string n, logic [9:0] e, logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_n(string n, int e, int g);
    checks_done++;
    if (g != e) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask
  // Whole catch-up is about 46k cycles, so the ceiling leaves room
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic t_cbr_self();
    // Two refreshes first, so the entry gap is a real one
    for (int i = 0; i < 9000 && cbr_cnt < 2; i++) @(posedge core_clk);
    sr_req <= 1'b1;
    for (int i = 0; i < 5000 && in_self_refresh !== 1'b1; i++) @(posedge core_clk);
    #1;
    chk_v("sr ras_n", 10'h0000, {9'h0, ras_n});
    chk_v("sr cas_n", 10'h0000, {9'h0, cas_n});
    chk_n("entry gap ok", 1, int'(gap_cyc <= GAP_CYC));
    repeat (200) @(posedge core_clk);
    base = cbr_cnt + row_cnt;
    sr_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk_v("catchup busy", 10'h0001, {9'h0, catchup_busy});
    chk_v("long sr", 10'h0000, {9'h0, long_sr_seen});
    for (int i = 0; i < 80000 && catchup_busy === 1'b1; i++) @(posedge core_clk);
    #1;
    chk_n("catchup rows", dsr_pkg::REFRESH_ROWS, cbr_cnt + row_cnt - base);
  endtask
  task automatic t_row_dist();
    @(posedge core_clk);
    scheme <= 2'h1;
    base = row_cnt;
    for (int i = 0; i < 9000 && row_cnt < base + 2; i++) @(posedge core_clk);
    prev = last_row;
    for (int i = 0; i < 5000 && row_cnt < base + 3; i++) @(posedge core_clk);
    #1;
    chk_v("row step", prev + 10'h0001, last_row);
    // Timer restart, start and pin registers add three cycles to lead and gap
    chk_n("row gap", dsr_pkg::DIST_GAP_CYC + dsr_pkg::CAS_LEAD_CYC + 3, gap_cyc);
  endtask
  // Frozen mid refresh: ras would rise within 20 cycles if ce were ignored
  task automatic t_freeze();
    @(posedge core_clk);
    ce <= 1'b0;
    @(posedge core_clk);
    #1;
    prev = addr;
    chk_v("frozen ras_n start", 10'h0000, {9'h0, ras_n});
    repeat (30) @(posedge core_clk);
    #1;
    chk_v("frozen addr", prev, addr);
    chk_v("frozen ras_n", 10'h0000, {9'h0, ras_n});
    @(posedge core_clk);
    ce <= 1'b1;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    chk_v("rst ras_n", 10'h0001, {9'h0, ras_n});
    chk_v("rst addr", 10'h0000, addr);
    rst <= 1'b0;
    t_cbr_self();
    t_row_dist();
    t_freeze();
    stop_test();
  end
endmodule
